// *** core/vrb_pkg.sv ***
/*
 * Constants, field layout and shared helpers for the voice rate buffer access block.
 * Assumes a single system clock and a 16-bit core external register port.
 */
`default_nettype none

package vrb_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Buffer geometry
	localparam int VRB_NIBBLES = 36;
	localparam int VRB_TX_SPAN = 51;
	localparam logic [5:0] VRB_RX_LAST = 6'h23;
	localparam logic [5:0] VRB_TX_LAST = 6'h32;
	localparam logic [5:0] VRB_PTR_RST = 6'h00;
	localparam logic [35:0] VRB_MARK_RST = 36'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Register select (external register index within the bank)
	localparam logic [2:0] VRB_REG_PTRCTL = 3'h0;
	localparam logic [2:0] VRB_REG_DATA = 3'h1;

	// Pointer control field positions
	localparam int VRB_TXPTR_LSB = 0;
	localparam int VRB_TXAUTO_BIT = 6;
	localparam int VRB_RXPTR_LSB = 8;
	localparam int VRB_RXAUTO_BIT = 14;

	// Control words reached through the data port beyond the transmit nibbles
	localparam logic [5:0] VRB_CW_TXVP = 6'h24;
	localparam logic [5:0] VRB_CW_RXVP = 6'h25;
	localparam logic [5:0] VRB_CW_MARK0 = 6'h26;
	localparam logic [5:0] VRB_CW_MARK1 = 6'h27;
	localparam logic [5:0] VRB_CW_MARK2 = 6'h28;
	localparam int VRB_MARK_W = 12;

	////////////////////////////////////////////////////////////////////////////////
	// Advance a pointer by one, wrapping after the given last index
	function automatic logic [5:0] vrb_step(input logic [5:0] ptr, input logic [5:0] last);
		vrb_step = (ptr >= last) ? 6'h00 : ptr + 6'h01;
	endfunction : vrb_step

	// First marked location at or after start, wrapping; bit 6 set when one exists
	function automatic logic [6:0] vrb_seek(input logic [5:0] start, input logic [35:0] mark);
		logic [6:0] res;
		int idx;
		res = 7'h00;
		for (int i = VRB_NIBBLES - 1; i >= 0; i--) begin
			idx = (int'(start) + i) % VRB_NIBBLES;
			if (mark[idx]) begin
				res = {1'b1, 6'(idx)};
			end
		end
		vrb_seek = res;
	endfunction : vrb_seek

endpackage : vrb_pkg

`default_nettype wire

// *** core/vrb_nibble_mem.sv ***
/*
 * 36 x 4-bit nibble store with one write port and two registered read ports.
 * Assumes the caller arbitrates writers; out-of-range reads return zero.
 */
`timescale 1ns/10ps
`default_nettype none

module vrb_nibble_mem (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [3:0] wdata,
	input wire logic [5:0] ra_addr,
	output logic [3:0] ra_data,
	input wire logic [5:0] rb_addr,
	output logic [3:0] rb_data
);

	typedef struct packed {
		logic [35:0][3:0] mem;
		logic [3:0] qa;
		logic [3:0] qb;
	} vrb_mem_t;

	vrb_mem_t s_r;
	vrb_mem_t s_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Write and registered reads; index guarded so stray pointers cannot alias
	always_comb begin
		s_nxt = s_r;
		if (we && waddr <= vrb_pkg::VRB_RX_LAST) begin
			s_nxt.mem[waddr] = wdata;
		end
		s_nxt.qa = (ra_addr <= vrb_pkg::VRB_RX_LAST) ? s_r.mem[ra_addr] : 4'h0;
		s_nxt.qb = (rb_addr <= vrb_pkg::VRB_RX_LAST) ? s_r.mem[rb_addr] : 4'h0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ra_data = s_r.qa;
	assign rb_data = s_r.qb;

endmodule : vrb_nibble_mem

`default_nettype wire

// *** core/vrb_rate_buffer.sv ***
/*
 * Transmit and receive nibble rate buffers between the core register port and the voice processor.
 * Assumes the voice processor and the radio paths run on clk_sys; no resynchronisation is done.
 */
// Overview of operation
// - Receive autostep advances core pointer modulo 36
// - Separate core-writable voice-side pointers per buffer
// - Voice access advances its pointer past it
// - Three marker fields select accessible nibbles
// - Marker one lets voice processor access nibble
// - Marker zero skips to next marked nibble
// - Each buffer holds 36 four-bit nibbles
// - Transmit autostep wraps modulo 51 incl. controls
`timescale 1ns/10ps
`default_nettype none

module vrb_rate_buffer (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic vp_tx_valid,
	output logic vp_tx_ready,
	input wire logic [3:0] vp_tx_data,
	output logic vp_rx_valid,
	input wire logic vp_rx_ready,
	output logic [3:0] vp_rx_data,
	input wire logic rx_fill_wr,
	input wire logic [5:0] rx_fill_addr,
	input wire logic [3:0] rx_fill_data,
	input wire logic [5:0] tx_drain_addr,
	output logic [3:0] tx_drain_data
);

	typedef struct packed {
		logic [5:0] tx_ptr;
		logic tx_pointer_autostep;
		logic [5:0] rx_ptr;
		logic rx_pointer_autostep;
		logic [5:0] tx_voice_side_pointer;
		logic [5:0] rx_voice_side_pointer;
		logic [35:0] mark;
		logic rd_pend;
		logic [15:0] rdata;
		logic rvalid;
		logic [3:0] q0;
		logic [3:0] q1;
		logic [1:0] cnt;
		logic infl;
		logic [5:0] a0; // Location of q0
		logic [5:0] a1; // Location of q1
		logic [5:0] af; // Location of the fetch in flight
	} vrb_state_t;

	vrb_state_t s_r;
	vrb_state_t s_nxt;

	logic [3:0] core_rx_q;
	logic [3:0] vp_rx_q;
	logic ptr_wr;
	logic data_wr;
	logic core_tx_we;
	logic [6:0] tx_seek;
	logic [6:0] rx_seek;
	logic vp_tx_take;
	logic vp_pop;
	logic rx_flush;
	logic rx_issue;
	logic tx_we;
	logic [5:0] tx_waddr;
	logic [3:0] tx_wdata;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and voice-side access steering
	assign ptr_wr = reg_wr && reg_addr == vrb_pkg::VRB_REG_PTRCTL;
	assign data_wr = reg_wr && reg_addr == vrb_pkg::VRB_REG_DATA;
	assign core_tx_we = data_wr && s_r.tx_ptr <= vrb_pkg::VRB_RX_LAST;
	assign tx_seek = vrb_pkg::vrb_seek(s_r.tx_voice_side_pointer, s_r.mark);
	assign rx_seek = vrb_pkg::vrb_seek(s_r.rx_voice_side_pointer, s_r.mark);
	// Core write wins the transmit store; the voice processor just waits a cycle
	assign vp_tx_ready = tx_seek[6] && !core_tx_we;
	assign vp_tx_take = vp_tx_valid && vp_tx_ready;
	assign vp_rx_valid = s_r.cnt != 2'h0;
	assign vp_rx_data = s_r.q0;
	assign vp_pop = vp_rx_valid && vp_rx_ready;
	// A core write of the receive voice-side pointer or of any marker field discards prefetched nibbles
	assign rx_flush = data_wr && (s_r.tx_ptr == vrb_pkg::VRB_CW_RXVP || s_r.tx_ptr == vrb_pkg::VRB_CW_MARK0
		|| s_r.tx_ptr == vrb_pkg::VRB_CW_MARK1 || s_r.tx_ptr == vrb_pkg::VRB_CW_MARK2);
	assign rx_issue = rx_seek[6] && !rx_flush && ({1'b0, s_r.cnt} + {2'h0, s_r.infl}) < 3'h2;
	assign tx_we = core_tx_we || vp_tx_take;
	assign tx_waddr = core_tx_we ? s_r.tx_ptr : tx_seek[5:0];
	assign tx_wdata = core_tx_we ? reg_wdata[3:0] : vp_tx_data;
	assign reg_rdata = s_r.rdata;
	assign reg_rvalid = s_r.rvalid;

	////////////////////////////////////////////////////////////////////////////////
	// Buffers: transmit filled by core and voice processor, receive filled by the radio
	vrb_nibble_mem u_tx_mem (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.we(tx_we),
		.waddr(tx_waddr),
		.wdata(tx_wdata),
		.ra_addr(tx_drain_addr),
		.ra_data(tx_drain_data),
		.rb_addr(6'h00),
		.rb_data()
	);

	vrb_nibble_mem u_rx_mem (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.we(rx_fill_wr),
		.waddr(rx_fill_addr),
		.wdata(rx_fill_data),
		.ra_addr(s_r.rx_ptr),
		.ra_data(core_rx_q),
		.rb_addr(rx_seek[5:0]),
		.rb_data(vp_rx_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		s_nxt.rd_pend = reg_rd && !s_r.rd_pend;
		// Pointer control write
		if (ptr_wr) begin
			s_nxt.tx_ptr = reg_wdata[vrb_pkg::VRB_TXPTR_LSB +: 6];
			s_nxt.tx_pointer_autostep = reg_wdata[vrb_pkg::VRB_TXAUTO_BIT];
			s_nxt.rx_ptr = reg_wdata[vrb_pkg::VRB_RXPTR_LSB +: 6];
			s_nxt.rx_pointer_autostep = reg_wdata[vrb_pkg::VRB_RXAUTO_BIT];
		end
		// Register reads: pointer control answers the next cycle, data one cycle after that
		if (reg_rd && reg_addr == vrb_pkg::VRB_REG_PTRCTL) begin
			s_nxt.rdata = {1'b0, s_r.rx_pointer_autostep, s_r.rx_ptr, 1'b0, s_r.tx_pointer_autostep, s_r.tx_ptr};
			s_nxt.rvalid = 1'b1;
			s_nxt.rd_pend = 1'b0;
		end else if (reg_rd && reg_addr != vrb_pkg::VRB_REG_DATA) begin
			s_nxt.rdata = 16'h0000;
			s_nxt.rvalid = 1'b1;
			s_nxt.rd_pend = 1'b0;
		end
		// Data read completes: nibble at the core receive pointer
		if (s_r.rd_pend) begin
			s_nxt.rdata = {12'h000, core_rx_q};
			s_nxt.rvalid = 1'b1;
			if (s_r.rx_pointer_autostep && !ptr_wr) begin
				s_nxt.rx_ptr = vrb_pkg::vrb_step(s_r.rx_ptr, vrb_pkg::VRB_RX_LAST);
			end
		end
		// Data port write: nibble or control word by transmit pointer
		if (data_wr) begin
			case (s_r.tx_ptr)
				vrb_pkg::VRB_CW_TXVP: s_nxt.tx_voice_side_pointer = reg_wdata[5:0];
				vrb_pkg::VRB_CW_RXVP: s_nxt.rx_voice_side_pointer = reg_wdata[5:0];
				vrb_pkg::VRB_CW_MARK0: s_nxt.mark[11:0] = reg_wdata[11:0];
				vrb_pkg::VRB_CW_MARK1: s_nxt.mark[23:12] = reg_wdata[11:0];
				vrb_pkg::VRB_CW_MARK2: s_nxt.mark[35:24] = reg_wdata[11:0];
				default: s_nxt.mark = s_nxt.mark;
			endcase
			if (s_r.tx_pointer_autostep && !ptr_wr) begin
				s_nxt.tx_ptr = vrb_pkg::vrb_step(s_r.tx_ptr, vrb_pkg::VRB_TX_LAST);
			end
		end
		// Voice processor transmit write lands on a marked nibble, pointer moves past it
		if (vp_tx_take && !(data_wr && s_r.tx_ptr == vrb_pkg::VRB_CW_TXVP)) begin
			s_nxt.tx_voice_side_pointer = vrb_pkg::vrb_step(tx_seek[5:0], vrb_pkg::VRB_RX_LAST);
		end
		// Receive prefetch into the two-entry buffer so a stalled reader loses nothing
		if (rx_issue) begin
			s_nxt.rx_voice_side_pointer = vrb_pkg::vrb_step(rx_seek[5:0], vrb_pkg::VRB_RX_LAST);
			s_nxt.af = rx_seek[5:0];
		end
		s_nxt.infl = rx_issue;
		if (rx_flush) begin
			s_nxt.cnt = 2'h0;
			// Marker change hands back nibbles fetched but not taken, else they would be skipped
			if (s_r.tx_ptr != vrb_pkg::VRB_CW_RXVP) begin
				if (vp_pop && s_r.cnt == 2'h2) begin
					s_nxt.rx_voice_side_pointer = s_r.a1;
				end else if (!vp_pop && s_r.cnt != 2'h0) begin
					s_nxt.rx_voice_side_pointer = s_r.a0;
				end else if (s_r.infl) begin
					s_nxt.rx_voice_side_pointer = s_r.af;
				end
			end
		end else begin
			if (vp_pop) begin
				s_nxt.q0 = s_r.q1;
				s_nxt.a0 = s_r.a1;
				s_nxt.cnt = s_nxt.cnt - 2'h1;
			end
			if (s_r.infl) begin
				if (s_nxt.cnt == 2'h0) begin
					s_nxt.q0 = vp_rx_q;
					s_nxt.a0 = s_r.af;
				end else begin
					s_nxt.q1 = vp_rx_q;
					s_nxt.a1 = s_r.af;
				end
				s_nxt.cnt = s_nxt.cnt + 2'h1;
			end
		end
	end

	// State register; reset clears every pointer and both autostep bits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.tx_ptr <= vrb_pkg::VRB_PTR_RST;
			s_r.rx_ptr <= vrb_pkg::VRB_PTR_RST;
			s_r.tx_voice_side_pointer <= vrb_pkg::VRB_PTR_RST;
			s_r.rx_voice_side_pointer <= vrb_pkg::VRB_PTR_RST;
			s_r.mark <= vrb_pkg::VRB_MARK_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_data_req;
		reg_rd && reg_addr == vrb_pkg::VRB_REG_DATA && !s_r.rd_pend;
	endsequence

	sequence s_data_ans;
		##1 s_r.rd_pend ##1 reg_rvalid;
	endsequence

	AST_DATA_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_data_req |-> s_data_ans) else $error("data read not answered in two cycles");

	AST_RX_AUTOSTEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_r.rd_pend && s_r.rx_pointer_autostep && !ptr_wr
		|=> s_r.rx_ptr == vrb_pkg::vrb_step($past(s_r.rx_ptr), vrb_pkg::VRB_RX_LAST))
		else $error("receive pointer did not step");

	AST_TX_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		data_wr && !ptr_wr && s_r.tx_pointer_autostep && s_r.tx_ptr == vrb_pkg::VRB_TX_LAST
		|=> s_r.tx_ptr == 6'h00) else $error("transmit pointer did not wrap at 51");

	AST_VP_PTR_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		data_wr && s_r.tx_ptr == vrb_pkg::VRB_CW_RXVP
		|=> s_r.rx_voice_side_pointer == $past(reg_wdata[5:0]) && s_r.cnt == 2'h0)
		else $error("receive voice pointer not loaded");

	AST_MARK_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		data_wr && s_r.tx_ptr == vrb_pkg::VRB_CW_MARK1 |=> s_r.mark[23:12] == $past(reg_wdata[11:0]))
		else $error("marker field not loaded");

	AST_TX_MARKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
		vp_tx_take |-> s_r.mark[tx_waddr] && !core_tx_we) else $error("voice write to unmarked nibble");

	AST_TX_NOSKIP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		vp_tx_take && s_r.mark[s_r.tx_voice_side_pointer] |-> tx_waddr == s_r.tx_voice_side_pointer)
		else $error("marked nibble was skipped");

	AST_TX_SKIP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		vp_tx_take && !s_r.mark[s_r.tx_voice_side_pointer] |-> tx_waddr != s_r.tx_voice_side_pointer)
		else $error("unmarked nibble was not skipped");

	AST_TX_VP_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		vp_tx_take && !data_wr
		|=> s_r.tx_voice_side_pointer == vrb_pkg::vrb_step($past(tx_waddr), vrb_pkg::VRB_RX_LAST))
		else $error("transmit voice pointer did not advance");

	AST_RX_FILL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rx_issue ##1 (!rx_flush && !vp_pop) |=> s_r.cnt == $past(s_r.cnt) + 2'h1)
		else $error("prefetched nibble lost");

	AST_RX_REWIND: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rx_flush && s_r.tx_ptr != vrb_pkg::VRB_CW_RXVP && s_r.cnt == 2'h0 && s_r.infl
		|=> s_r.rx_voice_side_pointer == $past(s_r.af)) else $error("fetch in flight not handed back");

endmodule : vrb_rate_buffer

`default_nettype wire

// *** testbench/vrb_voice_model.sv ***
/*
 * Voice processor data side: offers transmit nibbles and takes receive nibbles.
 * Assumes the bench calls its tasks and that it shares clk_sys with the buffer.
 */
`timescale 1ns/10ps
`default_nettype none

module vrb_voice_model (
	input wire logic clk_sys,
	output logic vp_tx_valid,
	input wire logic vp_tx_ready,
	output logic [3:0] vp_tx_data,
	input wire logic vp_rx_valid,
	output logic vp_rx_ready,
	input wire logic [3:0] vp_rx_data
);
	// Idle: nothing offered, nothing taken
	initial begin
		vp_tx_valid = 1'b0;
		vp_tx_data = 4'h0;
		vp_rx_ready = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hold the nibble until taken; afterwards show junk so stale data cannot pass
	task send_nib(input logic [3:0] d);
		@(posedge clk_sys);
		#1 vp_tx_valid = 1'b1;
		vp_tx_data = d;
		do @(posedge clk_sys); while (vp_tx_ready !== 1'b1);
		#1 vp_tx_valid = 1'b0;
		vp_tx_data = ~d;
	endtask : send_nib

	// Stall for lag cycles, then take one nibble
	task get_nib(input int lag, output logic [3:0] d);
		repeat (lag + 1) @(posedge clk_sys);
		#1 vp_rx_ready = 1'b1;
		do @(posedge clk_sys); while (vp_rx_valid !== 1'b1);
		d = vp_rx_data;
		#1 vp_rx_ready = 1'b0;
	endtask : get_nib
endmodule : vrb_voice_model

`default_nettype wire

// *** testbench/voice_rate_buffer_access_test.sv ***
/*
 * Self-checking bench for the rate buffers: core register port, voice side, radio paths.
 * Assumes vrb_pkg, vrb_rate_buffer and vrb_voice_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module voice_rate_buffer_access_test;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic vp_tx_valid, vp_tx_ready, vp_rx_valid, vp_rx_ready;
	logic [3:0] vp_tx_data, vp_rx_data, tx_drain_data;
	logic rx_fill_wr = 1'b0;
	logic [5:0] rx_fill_addr = 6'h00;
	logic [3:0] rx_fill_data = 4'h0;
	logic [5:0] tx_drain_addr = 6'h00;
	int n_fail = 0;
	int n_tests = 0;

	vrb_rate_buffer u_vrb_rate_buffer (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .vp_tx_valid(vp_tx_valid), .vp_tx_ready(vp_tx_ready),
		.vp_tx_data(vp_tx_data), .vp_rx_valid(vp_rx_valid), .vp_rx_ready(vp_rx_ready),
		.vp_rx_data(vp_rx_data), .rx_fill_wr(rx_fill_wr), .rx_fill_addr(rx_fill_addr),
		.rx_fill_data(rx_fill_data), .tx_drain_addr(tx_drain_addr), .tx_drain_data(tx_drain_data));
	vrb_voice_model u_vrb_voice_model (.clk_sys(clk_sys), .vp_tx_valid(vp_tx_valid),
		.vp_tx_ready(vp_tx_ready), .vp_tx_data(vp_tx_data), .vp_rx_valid(vp_rx_valid),
		.vp_rx_ready(vp_rx_ready), .vp_rx_data(vp_rx_data));

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	// Receive pattern: repeats every 16 locations, so a pointer off by less than 16 shows
	function automatic logic [3:0] pat(input int i);
		pat = 4'(i) ^ 4'ha;
	endfunction : pat

	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One write strobe; the next access waits for a fresh edge
	task reg_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1 reg_wr = 1'b0;
	endtask : reg_write

	// Read strobe, then a bounded wait for the answer pulse
	task reg_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		d = 16'hxxxx;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_sys);
			if (reg_rvalid === 1'b1) begin
				d = reg_rdata;
				break;
			end
		end
	endtask : reg_read

	task drain(input logic [5:0] a, input logic [3:0] exp);
		@(posedge clk_sys);
		#1 tx_drain_addr = a;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk({12'h000, tx_drain_data}, {12'h000, exp}, "tx store");
	endtask : drain

	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		logic [15:0] d;
		chk({15'h0, vp_tx_ready}, 16'h0000, "ready at reset");
		chk({15'h0, vp_rx_valid}, 16'h0000, "valid at reset");
		reg_read(vrb_pkg::VRB_REG_PTRCTL, d);
		chk(d, 16'h0000, "pointers at reset");
		$display("t_reset done");
	endtask : t_reset

	// Read across the end of the receive buffer with autostep on
	task t_rx_core;
		logic [15:0] d;
		for (int i = 0; i < 36; i++) begin
			@(posedge clk_sys);
			#1 rx_fill_wr = 1'b1;
			rx_fill_addr = 6'(i);
			rx_fill_data = pat(i);
		end
		@(posedge clk_sys);
		#1 rx_fill_wr = 1'b0;
		reg_write(vrb_pkg::VRB_REG_PTRCTL, 16'h6200);
		reg_read(vrb_pkg::VRB_REG_DATA, d);
		chk(d, {12'h000, pat(34)}, "rx read 34");
		reg_read(vrb_pkg::VRB_REG_DATA, d);
		chk(d, {12'h000, pat(35)}, "rx read 35");
		reg_read(vrb_pkg::VRB_REG_DATA, d);
		chk(d, {12'h000, pat(0)}, "rx read wrap");
		reg_read(vrb_pkg::VRB_REG_PTRCTL, d);
		chk(d, 16'h4100, "rx pointer after wrap");
		$display("t_rx_core done");
	endtask : t_rx_core

	// Transmit pointer wraps from 50 to 0
	task t_tx_core;
		logic [15:0] d;
		reg_write(vrb_pkg::VRB_REG_PTRCTL, 16'h0072);
		reg_write(vrb_pkg::VRB_REG_DATA, 16'h0009);
		reg_read(vrb_pkg::VRB_REG_PTRCTL, d);
		chk(d, 16'h0040, "tx pointer wrap");
		reg_write(vrb_pkg::VRB_REG_DATA, 16'h0005);
		drain(6'h00, 4'h5);
		$display("t_tx_core done");
	endtask : t_tx_core

	// Markers on 2 and 35 only; both voice pointers skip the rest
	task t_voice;
		logic [15:0] d;
		logic [3:0] n;
		reg_write(vrb_pkg::VRB_REG_PTRCTL, 16'h0064);
		reg_write(vrb_pkg::VRB_REG_DATA, 16'h0022);
		reg_write(vrb_pkg::VRB_REG_DATA, 16'h0000);
		reg_write(vrb_pkg::VRB_REG_DATA, 16'h0004);
		reg_write(vrb_pkg::VRB_REG_DATA, 16'h0000);
		reg_write(vrb_pkg::VRB_REG_DATA, 16'h0800);
		reg_read(vrb_pkg::VRB_REG_PTRCTL, d);
		chk(d, 16'h0069, "tx pointer past controls");
		chk({15'h0, vp_tx_ready}, 16'h0001, "ready with markers");
		u_vrb_voice_model.send_nib(4'h1);
		u_vrb_voice_model.send_nib(4'h2);
		u_vrb_voice_model.send_nib(4'h3);
		drain(6'h23, 4'h3);
		drain(6'h02, 4'h2);
		drain(6'h22, 4'h0);
		u_vrb_voice_model.get_nib(6, n);
		chk({12'h000, n}, {12'h000, pat(2)}, "voice rx first");
		u_vrb_voice_model.get_nib(0, n);
		chk({12'h000, n}, {12'h000, pat(35)}, "voice rx skip");
		u_vrb_voice_model.get_nib(3, n);
		chk({12'h000, n}, {12'h000, pat(2)}, "voice rx wrap");
		$display("t_voice done");
	endtask : t_voice

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		t_reset();
		t_rx_core();
		t_tx_core();
		t_voice();
		wrap_up();
	end

	// Watchdog: the tests need well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		wrap_up();
	end
endmodule : voice_rate_buffer_access_test

`default_nettype wire
